/* core/uart_irq_map.svh */
// Register offsets, field positions, codes and reset values of the UART channel control block.
// Assumes inclusion by bare name from the design module, the checker and the bench.
`ifndef UART_IRQ_MAP_SVH
`define UART_IRQ_MAP_SVH
// Byte offsets on the register bus.
`define OFS_INTERRUPT_ENABLE 8'h00
`define OFS_STATUS_FIFO 8'h04
`define OFS_LINE_CONTROL 8'h08
`define OFS_ENHANCED_FEATURE 8'h0c
`define OFS_LINE_STATUS 8'h10
`define OFS_MODEM_STATUS 8'h14
`define OFS_RECEIVE_HOLDING 8'h18
`define OFS_TRANSMIT_HOLDING 8'h1c
// Reset values.
`define RST_BYTE 8'h00
`define RST_TRIGGER 6'h08
// Field positions.
`define IE_RX 0
`define IE_TX 1
`define IE_LINE 2
`define IE_MODEM 3
`define IE_XOFF 5
`define IE_RTS 6
`define IE_CTS 7
`define EF_ENABLE 4
`define EF_AUTO_RTS 6
`define EF_AUTO_CTS 7
`define FC_ENABLE 0
`define FC_RX_RESET 1
`define FC_TX_RESET 2
`define FC_DMA 3
`define LC_STOP 2
`define LC_PARITY 3
`define LC_EVEN 4
// Status codes in bits 5:0, by priority level.
`define CODE_LINE 6'h06
`define CODE_TIMEOUT 6'h0c
`define CODE_RX_READY 6'h04
`define CODE_TX_READY 6'h02
`define CODE_MODEM 6'h00
`define CODE_XOFF 6'h10
`define CODE_FLOW 6'h20
`define CODE_NONE 6'h01
// Trigger levels in characters, then the base word length in bits.
`define TRIG_8 6'h08
`define TRIG_16 6'h10
`define TRIG_24 6'h18
`define TRIG_30 6'h1e
`define TRIG_ONE 6'h01
`define LEVEL_EMPTY 6'h00
`define WORD_BASE 4'h5
`endif

/* core/uart_irq_pkg.sv */
// Types shared by the UART channel control modules.
// Assumes uart_irq_map.svh is on the include path.
package uart_irq_pkg;
  // Interrupt sources by priority; index 0 is the highest.
  typedef enum logic [2:0] {
    SRC_LINE = 3'b000,
    SRC_TIMEOUT = 3'b001,
    SRC_RX_READY = 3'b010,
    SRC_TX_READY = 3'b011,
    SRC_MODEM = 3'b100,
    SRC_XOFF = 3'b101,
    SRC_FLOW = 3'b110,
    SRC_NONE = 3'b111
  } src_e;
endpackage : uart_irq_pkg

/* core/irq_src_if.sv */
// Carries the pending interrupt vector to the priority encoder and the winner back.
// Assumes both ends run on the same clock.
`timescale 1ns/1ps
interface irq_src_if;
  import uart_irq_pkg::*;
  logic [6:0] pending;
  src_e top;
  modport src (output pending, input top);
  modport enc (input pending, output top);
endinterface : irq_src_if

/* core/rise_detect.sv */
// Rising edge detector with an optional two-stage synchroniser in front.
// Assumes clk and nrst of the enclosing block; the pulse lasts one cycle.
`timescale 1ns/1ps
module rise_detect #(
  parameter bit SYNC = 1'b0
) (
  input wire logic clk,
  input wire logic nrst,
  input wire logic level,
  output logic rise
);
  logic meta;
  logic stable;
  logic prev;

  // The first stage feeds only the second stage.
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      meta <= 1'b0;
      stable <= 1'b0;
    end else begin
      meta <= level;
      stable <= SYNC ? meta : level;
    end
  end

  // Remember the last settled level to find low-to-high changes.
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      prev <= 1'b0;
    end else begin
      prev <= stable;
    end
  end

  assign rise = stable & ~prev;
endmodule : rise_detect

/* core/irq_priority.sv */
// Picks the highest-priority pending interrupt source.
// Assumes pending bit 0 is the highest priority.
`timescale 1ns/1ps
module irq_priority
  import uart_irq_pkg::*;
(
  irq_src_if.enc bus
);
  // Lowest set index wins.
  always_comb begin
    bus.top = SRC_NONE;
    for (int i = 6; i >= 0; i--) begin
      if (bus.pending[i]) begin
        bus.top = src_e'(i[2:0]);
      end
    end
  end
endmodule : irq_priority

/* core/uart_irq_fifo_lcr.sv */
// UART channel interrupt prioritisation, FIFO control and line format registers.
// Assumes the datapath on the same clock supplies line and modem status, FIFO levels,
// character timeout and flow-control events; only the clear-to-send pin is asynchronous.
//
// Added by the designer: the Avalon-MM register port and the register addresses.
`timescale 1ns/1ps
`include "uart_irq_map.svh"
module uart_irq_fifo_lcr
  import uart_irq_pkg::*;
(
  input wire logic clk,
  input wire logic nrst,
  input wire logic [7:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  input wire logic [7:0] line_status,
  input wire logic [3:0] modem_status,
  input wire logic [7:0] receive_data,
  input wire logic [5:0] rx_level,
  input wire logic [5:0] tx_level,
  input wire logic char_timeout,
  input wire logic xoff_match,
  input wire logic xon_match,
  input wire logic special_match,
  input wire logic rx_char,
  input wire logic rts_n_level,
  input wire logic cts_n_pin,
  output logic irq,
  output logic fifo_enable,
  output logic rx_fifo_reset,
  output logic tx_fifo_reset,
  output logic dma_mode,
  output logic [5:0] rx_trigger,
  output logic [5:0] tx_trigger,
  output logic [3:0] word_bits,
  output logic [1:0] stop_code,
  output logic parity_enable,
  output logic parity_even,
  output logic tx_write,
  output logic [7:0] transmit_holding,
  output logic rx_read
);
  logic [7:0] interrupt_enable;
  logic [7:0] enhanced_feature;
  logic [7:0] line_control;
  logic [7:0] prev_line;
  logic [3:0] prev_modem;
  logic [5:0] prev_tx;
  logic prev_tx_enable;
  logic tx_over;
  logic line_flag;
  logic modem_flag;
  logic timeout_flag;
  logic tx_flag;
  logic xoff_flag;
  logic special_flag;
  logic flow_flag;
  logic rts_rise;
  logic cts_rise;
  logic efr_on;
  logic take;
  logic wr_en;
  logic rd_status;
  logic rd_line;
  logic rd_modem;
  logic rd_rhr;
  logic wr_thr;
  logic wr_fcr;
  logic rx_ready;
  logic [5:0] trig_eff;
  logic [5:0] status_code;
  logic [7:0] status_byte;
  logic [7:0] next_read;
  src_e held;
  irq_src_if src_bus ();

  assign efr_on = enhanced_feature[`EF_ENABLE];
  // A request completes at the edge where waitrequest is low.
  assign take = (avs_read | avs_write) & ~avs_waitrequest;
  assign wr_en = take & avs_write & avs_byteenable[0];
  assign rd_status = take & avs_read & (avs_address == `OFS_STATUS_FIFO);
  assign rd_line = take & avs_read & (avs_address == `OFS_LINE_STATUS);
  assign rd_modem = take & avs_read & (avs_address == `OFS_MODEM_STATUS);
  assign rd_rhr = take & avs_read & (avs_address == `OFS_RECEIVE_HOLDING);
  assign wr_thr = wr_en & (avs_address == `OFS_TRANSMIT_HOLDING);
  assign wr_fcr = wr_en & (avs_address == `OFS_STATUS_FIFO);

  // Flow pin edges; the clear-to-send pin comes from outside and is synchronised.
  rise_detect #(.SYNC(1'b0)) rts_edge (
    .clk(clk),
    .nrst(nrst),
    .level(rts_n_level),
    .rise(rts_rise)
  );
  rise_detect #(.SYNC(1'b1)) cts_edge (
    .clk(clk),
    .nrst(nrst),
    .level(cts_n_pin),
    .rise(cts_rise)
  );

  // One wait cycle per request, then a single ready cycle.
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      avs_waitrequest <= 1'b1;
    end else begin
      avs_waitrequest <= ~((avs_read | avs_write) & avs_waitrequest);
    end
  end

  // Read data is captured while waitrequest is still high and stands at the ready edge.
  always_comb begin
    case (avs_address)
      `OFS_INTERRUPT_ENABLE: next_read = interrupt_enable;
      `OFS_STATUS_FIFO: next_read = status_byte;
      `OFS_LINE_CONTROL: next_read = line_control;
      `OFS_ENHANCED_FEATURE: next_read = enhanced_feature;
      `OFS_LINE_STATUS: next_read = line_status;
      `OFS_MODEM_STATUS: next_read = {4'h0, modem_status};
      `OFS_RECEIVE_HOLDING: next_read = receive_data;
      default: next_read = `RST_BYTE;
    endcase
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      avs_readdata <= 32'h0000_0000;
    end else if (avs_read & avs_waitrequest) begin
      avs_readdata <= {24'h00_0000, next_read};
    end
  end

  // Interrupt enable; the upper half is writable only with enhanced features on.
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      interrupt_enable <= `RST_BYTE;
    end else if (wr_en && avs_address == `OFS_INTERRUPT_ENABLE) begin
      interrupt_enable[3:0] <= avs_writedata[3:0];
      if (efr_on) begin
        interrupt_enable[7:4] <= avs_writedata[7:4];
      end
    end
  end

  // Enhanced feature and line control registers.
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      enhanced_feature <= `RST_BYTE;
      line_control <= `RST_BYTE;
    end else if (wr_en) begin
      if (avs_address == `OFS_ENHANCED_FEATURE) begin
        enhanced_feature <= avs_writedata[7:0];
      end
      if (avs_address == `OFS_LINE_CONTROL) begin
        line_control <= avs_writedata[7:0];
      end
    end
  end

  // Line format outputs decoded from line control.
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      word_bits <= `WORD_BASE;
      stop_code <= 2'h0;
      parity_enable <= 1'b0;
      parity_even <= 1'b0;
    end else begin
      word_bits <= `WORD_BASE + {2'h0, line_control[1:0]};
      if (!line_control[`LC_STOP]) begin
        stop_code <= 2'h0;
      end else begin
        stop_code <= (line_control[1:0] == 2'h0) ? 2'h1 : 2'h2;
      end
      parity_enable <= line_control[`LC_PARITY];
      parity_even <= line_control[`LC_EVEN];
    end
  end

  // FIFO control: bit 0 always, the rest only when bit 0 is set in the same write.
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      fifo_enable <= 1'b0;
      dma_mode <= 1'b0;
      rx_trigger <= `RST_TRIGGER;
      tx_trigger <= `TRIG_16;
      rx_fifo_reset <= 1'b0;
      tx_fifo_reset <= 1'b0;
    end else begin
      rx_fifo_reset <= 1'b0;
      tx_fifo_reset <= 1'b0;
      if (wr_fcr) begin
        fifo_enable <= avs_writedata[`FC_ENABLE];
        if (avs_writedata[`FC_ENABLE]) begin
          rx_fifo_reset <= avs_writedata[`FC_RX_RESET];
          tx_fifo_reset <= avs_writedata[`FC_TX_RESET];
          dma_mode <= avs_writedata[`FC_DMA];
          case (avs_writedata[7:6])
            2'h0: rx_trigger <= `TRIG_8;
            2'h1: rx_trigger <= `TRIG_16;
            2'h2: rx_trigger <= `TRIG_24;
            default: rx_trigger <= `TRIG_30;
          endcase
          if (efr_on) begin
            case (avs_writedata[5:4])
              2'h0: tx_trigger <= `TRIG_16;
              2'h1: tx_trigger <= `TRIG_8;
              2'h2: tx_trigger <= `TRIG_24;
              default: tx_trigger <= `TRIG_30;
            endcase
          end
        end
      end
    end
  end

  // Transmit holding writes and receive holding reads are passed to the datapath.
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      tx_write <= 1'b0;
      rx_read <= 1'b0;
      transmit_holding <= `RST_BYTE;
    end else begin
      tx_write <= wr_thr;
      rx_read <= rd_rhr;
      if (wr_thr) begin
        transmit_holding <= avs_writedata[7:0];
      end
    end
  end

  // Status history used to find new events.
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      prev_line <= `RST_BYTE;
      prev_modem <= 4'h0;
      prev_tx <= `LEVEL_EMPTY;
      prev_tx_enable <= 1'b0;
      tx_over <= 1'b0;
    end else begin
      prev_line <= line_status;
      prev_modem <= modem_status;
      prev_tx <= tx_level;
      prev_tx_enable <= interrupt_enable[`IE_TX];
      if (tx_level > trig_eff) begin
        tx_over <= 1'b1;
      end else if (tx_level == `LEVEL_EMPTY) begin
        tx_over <= 1'b0;
      end
    end
  end

  // Line and modem flags; a new event wins over a clearing read in the same cycle.
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      line_flag <= 1'b0;
      modem_flag <= 1'b0;
      timeout_flag <= 1'b0;
    end else begin
      if (|(line_status[4:1] & ~prev_line[4:1])) begin
        line_flag <= 1'b1;
      end else if (rd_line) begin
        line_flag <= 1'b0;
      end
      if (|(modem_status & ~prev_modem)) begin
        modem_flag <= 1'b1;
      end else if (rd_modem) begin
        modem_flag <= 1'b0;
      end
      if (char_timeout) begin
        timeout_flag <= 1'b1;
      end else if (rd_rhr) begin
        timeout_flag <= 1'b0;
      end
    end
  end

  // Without FIFOs the transmit threshold is a single character.
  assign trig_eff = fifo_enable ? tx_trigger : `TRIG_ONE;
  assign rx_ready = fifo_enable ? (rx_level >= rx_trigger) : (rx_level != `LEVEL_EMPTY);

  // Transmit ready: falling below trigger, or empty after a reload that stayed at or under it.
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      tx_flag <= 1'b0;
    end else if ((prev_tx >= trig_eff && tx_level < trig_eff)
                 || (tx_level == `LEVEL_EMPTY && prev_tx != `LEVEL_EMPTY && !tx_over)
                 || (interrupt_enable[`IE_TX] && !prev_tx_enable
                     && tx_level == `LEVEL_EMPTY)) begin
      tx_flag <= 1'b1;
    end else if ((rd_status && held == SRC_TX_READY) || wr_thr) begin
      tx_flag <= 1'b0;
    end
  end

  // Xoff and special character flags behind status bit 4.
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      xoff_flag <= 1'b0;
      special_flag <= 1'b0;
    end else begin
      if (xoff_match) begin
        xoff_flag <= 1'b1;
      end else if ((rd_status && held == SRC_XOFF) || xon_match) begin
        xoff_flag <= 1'b0;
      end
      if (special_match) begin
        special_flag <= 1'b1;
      end else if ((rd_status && held == SRC_XOFF) || rx_char) begin
        special_flag <= 1'b0;
      end
    end
  end

  // Flow-control pin change flag behind status bit 5.
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      flow_flag <= 1'b0;
    end else if ((rts_rise && interrupt_enable[`IE_RTS] && efr_on
                  && enhanced_feature[`EF_AUTO_RTS])
                 || (cts_rise && interrupt_enable[`IE_CTS] && efr_on
                     && enhanced_feature[`EF_AUTO_CTS])) begin
      flow_flag <= 1'b1;
    end else if (rd_modem) begin
      flow_flag <= 1'b0;
    end
  end

  // Enabled sources in priority order.
  assign src_bus.pending = {
    flow_flag & efr_on,
    (xoff_flag | special_flag) & interrupt_enable[`IE_XOFF] & efr_on,
    modem_flag & interrupt_enable[`IE_MODEM],
    tx_flag & interrupt_enable[`IE_TX],
    rx_ready & interrupt_enable[`IE_RX],
    timeout_flag & interrupt_enable[`IE_RX],
    line_flag & interrupt_enable[`IE_LINE]
  };

  irq_priority prio (
    .bus(src_bus.enc)
  );

  // The reported source stays until it is serviced; only then is the next one taken.
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      held <= SRC_NONE;
    end else if (held == SRC_NONE || !src_bus.pending[held]) begin
      held <= src_bus.top;
    end
  end

  // Status code of the reported source.
  always_comb begin
    case (held)
      SRC_LINE: status_code = `CODE_LINE;
      SRC_TIMEOUT: status_code = `CODE_TIMEOUT;
      SRC_RX_READY: status_code = `CODE_RX_READY;
      SRC_TX_READY: status_code = `CODE_TX_READY;
      SRC_MODEM: status_code = `CODE_MODEM;
      SRC_XOFF: status_code = `CODE_XOFF;
      SRC_FLOW: status_code = `CODE_FLOW;
      default: status_code = `CODE_NONE;
    endcase
  end

  assign status_byte = {fifo_enable, fifo_enable, status_code};

  // Interrupt output follows the reported source.
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      irq <= 1'b0;
    end else begin
      irq <= (held != SRC_NONE) && src_bus.pending[held];
    end
  end
endmodule : uart_irq_fifo_lcr

/* testbench/uart_irq_fifo_lcr_asserts.sv */
// Checker for the register port and format outputs of the UART channel control block.
// Assumes one clock and that a write lands at the edge where waitrequest is seen low.
`timescale 1ns/1ps
`include "uart_irq_map.svh"
module uart_irq_fifo_lcr_asserts (
  input wire logic clk,
  input wire logic nrst,
  input wire logic [7:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  input wire logic [31:0] avs_readdata,
  input wire logic avs_waitrequest,
  input wire logic fifo_enable,
  input wire logic rx_fifo_reset,
  input wire logic tx_fifo_reset,
  input wire logic [5:0] rx_trigger,
  input wire logic [5:0] tx_trigger,
  input wire logic [3:0] word_bits,
  input wire logic tx_write,
  input wire logic rx_read
);
  logic ef_on;
  logic wdone;
  logic rdone;
  logic w_fc;
  logic [7:0] wd;
  // Completed transfers, decoded once.
  assign wd = avs_writedata[7:0];
  assign wdone = avs_write && !avs_waitrequest && avs_byteenable[0];
  assign rdone = avs_read && !avs_waitrequest;
  assign w_fc = wdone && avs_address == `OFS_STATUS_FIFO;
  // Follows the enhanced enable so that trigger writes can be judged.
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      ef_on <= 1'b0;
    end else if (wdone && avs_address == `OFS_ENHANCED_FEATURE) begin
      ef_on <= wd[`EF_ENABLE];
    end
  end
  // Receive trigger table.
  function automatic logic [5:0] rx_trig(input logic [1:0] c);
    return c == 2'h0 ? `TRIG_8 : c == 2'h1 ? `TRIG_16 : c == 2'h2 ? `TRIG_24 : `TRIG_30;
  endfunction : rx_trig
  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);
  property p_fifo_on;
    w_fc && wd[0] |=> fifo_enable && rx_trigger == rx_trig($past(wd[7:6]));
  endproperty
  a_fifo_on: assert property (p_fifo_on) else $error("fifo enable write not applied");
  property p_fifo_off;
    w_fc && !wd[0] |=> !fifo_enable && $stable(rx_trigger) && !rx_fifo_reset;
  endproperty
  a_fifo_off: assert property (p_fifo_off) else $error("fifo bits taken without enable");
  property p_rx_reset;
    w_fc && wd[0] |=> {tx_fifo_reset, rx_fifo_reset} == $past(wd[2:1])
      ##1 !rx_fifo_reset && !tx_fifo_reset;
  endproperty
  a_rx_reset: assert property (p_rx_reset) else $error("fifo reset pulse wrong");
  // The transmit table is the receive table with code bit 0 flipped while bit 1 is low.
  property p_tx_trig;
    w_fc && wd[0] && ef_on |=> tx_trigger == rx_trig($past({wd[5], wd[4] ^ !wd[5]}));
  endproperty
  a_tx_trig: assert property (p_tx_trig) else $error("transmit trigger wrong");
  property p_tx_lock;
    w_fc && !ef_on |=> $stable(tx_trigger);
  endproperty
  a_tx_lock: assert property (p_tx_lock) else $error("transmit trigger changed");
  property p_word;
    wdone && avs_address == `OFS_LINE_CONTROL |-> ##2 word_bits == `WORD_BASE + $past(wd[1:0], 2);
  endproperty
  a_word: assert property (p_word) else $error("word length wrong");
  property p_status_hi;
    rdone && avs_address == `OFS_STATUS_FIFO |->
      avs_readdata[7:6] == {2{fifo_enable}} && avs_readdata[31:8] == 24'h0;
  endproperty
  a_status_hi: assert property (p_status_hi) else $error("status fifo bits wrong");
  property p_rx_read;
    rdone && avs_address == `OFS_RECEIVE_HOLDING |-> ##[1:2] rx_read;
  endproperty
  a_rx_read: assert property (p_rx_read) else $error("receive read pulse missing");
  property p_tx_write;
    wdone && avs_address == `OFS_TRANSMIT_HOLDING |-> ##[1:2] tx_write;
  endproperty
  a_tx_write: assert property (p_tx_write) else $error("transmit write pulse missing");
  c_pending: cover property (rdone && avs_address == `OFS_STATUS_FIFO && !avs_readdata[0]);
  c_reset: cover property (rx_fifo_reset);
  c_tx: cover property (tx_write);
endmodule : uart_irq_fifo_lcr_asserts
bind uart_irq_fifo_lcr uart_irq_fifo_lcr_asserts u_chk (.clk, .nrst, .avs_address, .avs_read,
  .avs_write, .avs_writedata, .avs_byteenable, .avs_readdata, .avs_waitrequest, .fifo_enable,
  .rx_fifo_reset, .tx_fifo_reset, .rx_trigger, .tx_trigger, .word_bits, .tx_write, .rx_read);

/* testbench/host_bus_model.sv */
// Host processor model that masters the register port.
// Assumes the slave answers by lowering waitrequest; gives up after 16 edges.
`timescale 1ns/1ps
module host_bus_model (
  input wire logic clk,
  output logic [7:0] avs_address,
  output logic avs_read,
  output logic avs_write,
  output logic [31:0] avs_writedata,
  output logic [3:0] avs_byteenable,
  input wire logic [31:0] avs_readdata,
  input wire logic avs_waitrequest
);
  // Idle bus at time zero.
  initial begin
    avs_address = 8'h00;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_writedata = 32'h0;
    avs_byteenable = 4'h1;
  end
  // One transfer, held until waitrequest is sampled low; released lines show inverted data.
  task automatic xfer(input logic w, input logic [7:0] a, input logic [7:0] d,
                      output logic [31:0] q, output logic ok);
    int n;
    @(posedge clk);
    avs_address <= a;
    avs_read <= !w;
    avs_write <= w;
    avs_writedata <= {24'h0, d};
    ok = 1'b0;
    q = 32'h0;
    for (n = 0; n < 16 && !ok; n++) begin
      @(posedge clk);
      if (avs_waitrequest === 1'b0) begin
        ok = 1'b1;
        q = avs_readdata;
      end
    end
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    avs_address <= ~a;
    avs_writedata <= ~{24'h0, d};
  endtask : xfer
endmodule : host_bus_model

/* testbench/uart_irq_fifo_lcr_tb_top.sv */
// Self-checking bench for the UART channel control block.
// Assumes the host model masters the register port; the bench plays the datapath.
`timescale 1ns/1ps
`include "uart_irq_map.svh"
module uart_irq_fifo_lcr_tb_top;
  logic clk, nrst, avs_read, avs_write, avs_waitrequest, irq, fifo_enable, dma_mode;
  logic char_timeout, xoff_match, xon_match, special_match, rx_char, rts_n_level, cts_n_pin;
  logic parity_enable, parity_even;
  logic [7:0] avs_address, line_status, transmit_holding;
  logic [31:0] avs_writedata, avs_readdata, rq;
  logic [3:0] avs_byteenable, modem_status, word_bits;
  logic [5:0] rx_level, tx_level, rx_trigger, tx_trigger;
  logic [1:0] stop_code;
  logic [5:0] rx_tab [4] = '{`TRIG_8, `TRIG_16, `TRIG_24, `TRIG_30};
  logic [5:0] tx_tab [4] = '{`TRIG_16, `TRIG_8, `TRIG_24, `TRIG_30};
  int n_errors = 0;
  int compares = 0;
  // Device under test and the host on its register port.
  uart_irq_fifo_lcr dut (.clk, .nrst, .avs_address, .avs_read, .avs_write, .avs_writedata,
    .avs_byteenable, .avs_readdata, .avs_waitrequest, .line_status, .modem_status,
    .receive_data(8'h5a), .rx_level, .tx_level, .char_timeout, .xoff_match, .xon_match,
    .special_match, .rx_char, .rts_n_level, .cts_n_pin, .irq, .fifo_enable, .rx_fifo_reset(),
    .tx_fifo_reset(), .dma_mode, .rx_trigger, .tx_trigger, .word_bits, .stop_code,
    .parity_enable, .parity_even, .tx_write(), .transmit_holding, .rx_read());
  host_bus_model host (.clk, .avs_address, .avs_read, .avs_write, .avs_writedata,
    .avs_byteenable, .avs_readdata, .avs_waitrequest);
  // Free-running 100 MHz clock.
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  task automatic conclude();
    $display("compares %0d n_errors %0d", compares, n_errors);
    if (n_errors == 0 && compares > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : conclude
  task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      n_errors++;
      $display("mismatch %s expected %h seen %h", name, exp, seen);
    end
  endtask : chk
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
  endtask : tick
  // Bus transfer; a transfer that never completes ends the run.
  task automatic xfer(input logic w, input logic [7:0] a, input logic [7:0] d);
    logic ok;
    host.xfer(w, a, d, rq, ok);
    if (!ok) begin
      n_errors++;
      conclude();
    end
  endtask : xfer
  task automatic rd_chk(input string name, input logic [7:0] a, input logic [31:0] exp);
    xfer(1'b0, a, 8'h00);
    chk(name, rq, exp);
  endtask : rd_chk
  task automatic st_chk(input logic [31:0] exp);
    rd_chk("status", `OFS_STATUS_FIFO, exp);
  endtask : st_chk
  // One-cycle datapath event: 0 timeout, 1 xoff, 2 xon, 3 special, 4 character.
  task automatic pulse(input int k);
    char_timeout <= (k == 0);
    xoff_match <= (k == 1);
    xon_match <= (k == 2);
    special_match <= (k == 3);
    rx_char <= (k == 4);
    tick(1);
    {char_timeout, xoff_match, xon_match, special_match, rx_char} <= 5'h00;
    tick(3);
  endtask : pulse
  task automatic t_reset();
    chk("irq", irq, 1'b0);
    chk("rx_trigger", rx_trigger, `RST_TRIGGER);
    chk("tx_trigger", tx_trigger, `TRIG_16);
    st_chk(32'h01);
    rd_chk("unmapped", 8'h40, 32'h0);
    rd_chk("line_control", `OFS_LINE_CONTROL, 32'h0);
  endtask : t_reset
  task automatic t_fifo();
    xfer(1'b1, `OFS_STATUS_FIFO, 8'hfe);
    tick(2);
    chk("fifo_enable", fifo_enable, 1'b0);
    chk("dma_mode", dma_mode, 1'b0);
    xfer(1'b1, `OFS_STATUS_FIFO, 8'h31);
    tick(2);
    chk("tx_trigger", tx_trigger, `TRIG_16);
    xfer(1'b1, `OFS_ENHANCED_FEATURE, 8'h10);
    for (int i = 0; i < 4; i++) begin
      xfer(1'b1, `OFS_STATUS_FIFO, {i[1:0], i[1:0], i[0], 3'h7});
      tick(2);
      chk("rx_trigger", rx_trigger, rx_tab[i]);
      chk("tx_trigger", tx_trigger, tx_tab[i]);
      chk("dma_mode", dma_mode, i[0]);
      st_chk(32'hc1);
    end
    xfer(1'b1, `OFS_STATUS_FIFO, 8'h01);
  endtask : t_fifo
  task automatic t_line();
    logic [7:0] d;
    for (int i = 0; i < 4; i++) begin
      d = {3'h0, i[0], 2'h3, i[1:0]};
      xfer(1'b1, `OFS_LINE_CONTROL, d);
      tick(2);
      chk("word_bits", word_bits, 4'h5 + i[1:0]);
      chk("stop_code", stop_code, (i == 0) ? 2'h1 : 2'h2);
      chk("parity", {parity_enable, parity_even}, {1'b1, i[0]});
      rd_chk("line_control", `OFS_LINE_CONTROL, {24'h0, d});
    end
    xfer(1'b1, `OFS_LINE_CONTROL, 8'h03);
    tick(2);
    chk("stop_code", stop_code, 2'h0);
    chk("parity_enable", parity_enable, 1'b0);
  endtask : t_line
  // Sources are made pending while masked, then unmasked in one write so they compete.
  task automatic t_prio();
    xfer(1'b1, `OFS_INTERRUPT_ENABLE, 8'h00);
    line_status <= 8'h02;
    tick(4);
    chk("irq", irq, 1'b0);
    st_chk(32'hc1);
    xfer(1'b0, `OFS_LINE_STATUS, 8'h00);
    line_status <= 8'h04;
    modem_status <= 4'h1;
    rx_level <= 6'h08;
    pulse(0);
    xfer(1'b1, `OFS_INTERRUPT_ENABLE, 8'h0d);
    tick(3);
    chk("irq", irq, 1'b1);
    st_chk(32'hc6);
    st_chk(32'hc6);
    xfer(1'b0, `OFS_LINE_STATUS, 8'h00);
    tick(2);
    st_chk(32'hcc);
    rd_chk("receive_holding", `OFS_RECEIVE_HOLDING, 32'h5a);
    tick(2);
    st_chk(32'hc4);
    rx_level <= 6'h07;
    tick(3);
    st_chk(32'hc0);
    xfer(1'b0, `OFS_MODEM_STATUS, 8'h00);
    tick(3);
    st_chk(32'hc1);
    chk("irq", irq, 1'b0);
  endtask : t_prio
  task automatic t_tx();
    xfer(1'b1, `OFS_INTERRUPT_ENABLE, 8'h02);
    tick(2);
    st_chk(32'hc2);
    tick(2);
    st_chk(32'hc1);
    tx_level <= 6'h14;
    tick(2);
    tx_level <= 6'h0f;
    tick(4);
    chk("irq", irq, 1'b1);
    xfer(1'b1, `OFS_TRANSMIT_HOLDING, 8'ha5);
    tick(3);
    chk("transmit_holding", transmit_holding, 8'ha5);
    st_chk(32'hc1);
  endtask : t_tx
  // Bit 4 is cleared once by a status read and once by Xon or the next character.
  task automatic t_flow();
    xfer(1'b1, `OFS_ENHANCED_FEATURE, 8'hd0);
    xfer(1'b1, `OFS_INTERRUPT_ENABLE, 8'he0);
    for (int i = 1; i < 4; i += 2) begin
      pulse(i);
      st_chk(32'hd0);
      st_chk(32'hc1);
      pulse(i);
      pulse(i + 1);
      chk("irq", irq, 1'b0);
    end
    rts_n_level <= 1'b1;
    tick(4);
    st_chk(32'he0);
    st_chk(32'he0);
    xfer(1'b0, `OFS_MODEM_STATUS, 8'h00);
    tick(3);
    st_chk(32'hc1);
    cts_n_pin <= 1'b1;
    tick(6);
    st_chk(32'he0);
    xfer(1'b0, `OFS_MODEM_STATUS, 8'h00);
    tick(3);
    st_chk(32'hc1);
    xfer(1'b1, `OFS_ENHANCED_FEATURE, 8'h00);
    pulse(1);
    st_chk(32'hc1);
  endtask : t_flow
  // Reset, then the scenarios in turn.
  initial begin
    nrst = 1'b0;
    {line_status, modem_status, rx_level, tx_level} = 24'h0;
    {char_timeout, xoff_match, xon_match, special_match, rx_char} = 5'h00;
    rts_n_level = 1'b0;
    cts_n_pin = 1'b0;
    tick(10);
    nrst <= 1'b1;
    t_reset();
    t_fifo();
    t_line();
    t_prio();
    t_tx();
    t_flow();
    conclude();
  end
endmodule : uart_irq_fifo_lcr_tb_top
